// >>> pkg/ddr2_timing_map.svh
// Widths, field positions, command codes and timing counts of the command timing block.
`ifndef DDR2_TIMING_MAP_SVH
`define DDR2_TIMING_MAP_SVH

// ----------------------------------------------------------------------
// Pin group widths, bank count and counter width
// ----------------------------------------------------------------------
`define BANK_W            3
`define ADDR_W            14
`define BANK_COUNT        8
`define CNT_W             5

// ----------------------------------------------------------------------
// Command codes, ordered {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define CMD_MODE_LOAD     4'h0
`define CMD_REFRESH       4'h1
`define CMD_PRECHARGE     4'h2
`define CMD_ACTIVATE      4'h3
`define CMD_WRITE         4'h4
`define CMD_READ          4'h5

// ----------------------------------------------------------------------
// Mode configuration fields
// ----------------------------------------------------------------------
`define MODE_BANK_MAIN    3'h0
`define MODE_BANK_EXT     3'h1
`define AUTO_PRE_BIT      10
`define STROBE_MODE_BIT   10
`define WR_FIELD_LSB      9
`define WR_FIELD_MSB      11
`define WR_CLOCKS_RESET   4'h2
`define STROBE_RESET      1'b0

// ----------------------------------------------------------------------
// Timing: times in picoseconds, counts in link clock edges
// ----------------------------------------------------------------------
`define LINK_PERIOD_PS            64000
`define ROW_PRECHARGE_TIME_PS     15000
`define ROW_PRECHARGE_CYC  ((`ROW_PRECHARGE_TIME_PS + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS)
`define WRITE_TO_READ_GAP_CYC     2
`define CLOCK_ENABLE_MIN_HOLD_CYC 3
`define POWER_DOWN_EXIT_GAP_CYC   2

`endif

// >>> pkg/ddr2_timing_pkg.sv
// Types shared by the command timing block.
`default_nettype none
`include "ddr2_timing_map.svh"

package ddr2_timing_pkg;

  // Command and address pins as sampled on the link clock.
  typedef struct packed {
    logic                 cke;
    logic                 cs_n;
    logic                 ras_n;
    logic                 cas_n;
    logic                 we_n;
    logic [`BANK_W-1:0]   ba;
    logic [`ADDR_W-1:0]   addr;
  } cmd_pins_t;

  // Device state levels.
  typedef struct packed {
    logic strobe_single_ended;
    logic freq_change_ok;
    logic self_refresh;
    logic power_down;
  } dev_status_t;

  // Timing fault events.
  typedef struct packed {
    logic act_early;
    logic read_early;
    logic cke_glitch;
    logic exit_early;
    logic read_suspect;
  } fault_t;

  // Power states.
  typedef enum logic [3:0] {
    ST_ACTIVE   = 4'b0001,
    ST_PD_PRE   = 4'b0010,
    ST_PD_ACT   = 4'b0100,
    ST_SELF_REF = 4'b1000
  } power_state_t;

endpackage : ddr2_timing_pkg
`default_nettype wire

// >>> rtl/level_sync.sv
// Two flip-flop synchroniser for independent level bits.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,  // Destination clock.
  input  wire logic [WIDTH-1:0] d_in,    // Levels from another domain.
  output logic      [WIDTH-1:0] q_out    // Synchronised levels.
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------
  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out  <= meta_q;
  end

endmodule : level_sync
`default_nettype wire

// >>> rtl/ddr2_command_timing_rules.sv
// Device-side command timing monitor with link and system clock domains.
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing_map.svh"

// Operation
// R01: An auto-precharge write is followed by an activate no sooner than write recovery plus rounded row precharge clocks.
// R02: The write recovery clock count comes from the value last loaded into the mode configuration register.
// R03: Clock frequency may change only in self-refresh or precharge power-down, reported as a permission level.
// R04: Mode configuration bit 10 selects differential strobes at 0 and a single-ended strobe at 1.
// R05: A read needs at least two clocks after the last write.
// R06: Each clock enable level must stand for three consecutive registered edges before it changes again.
// R07: After a write data timing fault the data is suspect until rewritten, so a read before that is flagged.
// R08: Every timing count is the rounded-up clock count, and a command at exactly that count is accepted.
// R09: Counts are real clock edges, and an activate two edges after a power-down exit is accepted.
// R10: Per-bank down-counters loaded with the rounded counts minus one flag dependent commands issued before they reach zero.
module ddr2_command_timing_rules (
  input  wire logic                       ref_clk_in,     // System clock, 50 MHz.
  input  wire logic                       rstn_in,        // Synchronous reset, active low.
  input  wire logic                       link_clk_in,    // Command clock from the controller.
  input  wire ddr2_timing_pkg::cmd_pins_t cmd_pins_in,    // Command pins, link domain.
  input  wire logic                       data_fault_in,  // Write data timing fault, link domain.
  output ddr2_timing_pkg::dev_status_t    status_out,     // Device state levels.
  output ddr2_timing_pkg::fault_t         fault_out       // One-cycle fault pulses.
);
  import ddr2_timing_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Packs the four command strobes into one code.
  function automatic logic [3:0] cmd_code(input cmd_pins_t p);
    cmd_code = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
  endfunction : cmd_code

  // Counts down to zero and holds there.
  function automatic logic [`CNT_W-1:0] count_down(input logic [`CNT_W-1:0] c);
    count_down = (c != '0) ? c - `CNT_W'(1) : c;
  endfunction : count_down

  localparam logic [`CNT_W-1:0] RP_LOAD  = `CNT_W'(`ROW_PRECHARGE_CYC - 1);
  localparam logic [`CNT_W-1:0] WTR_LOAD = `CNT_W'(`WRITE_TO_READ_GAP_CYC - 1);
  localparam logic [`CNT_W-1:0] CKE_LOAD = `CNT_W'(`CLOCK_ENABLE_MIN_HOLD_CYC - 1);
  localparam logic [`CNT_W-1:0] XP_LOAD  = `CNT_W'(`POWER_DOWN_EXIT_GAP_CYC - 1);

  // ----------------------------------------------------------------------
  // Link domain reset
  // ----------------------------------------------------------------------
  logic link_rstn;

  level_sync #(.WIDTH(1)) u_link_rst_sync (
    .clk_in (link_clk_in),
    .d_in   (rstn_in),
    .q_out  (link_rstn)
  );

  // ----------------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------------
  power_state_t          state_q, state_d;
  logic                  cke_q, cke_d;
  logic [`CNT_W-1:0]     cke_hold_q, cke_hold_d;
  logic [`CNT_W-1:0]     act_cnt_q [`BANK_COUNT];
  logic [`CNT_W-1:0]     act_cnt_d [`BANK_COUNT];
  logic [`BANK_COUNT-1:0] open_q, open_d;
  logic [`CNT_W-1:0]     wtr_q, wtr_d;
  logic [`CNT_W-1:0]     xp_q, xp_d;
  logic [3:0]            wr_clocks_q, wr_clocks_d;
  logic                  strobe_q, strobe_d;
  logic                  suspect_q, suspect_d;
  fault_t                fault_tog_q, fault_tog_d;
  fault_t                ev;
  logic [3:0]            code;
  logic                  cmd_ok;

  // Command decode, timing counters and power state.
  always_comb begin
    state_d     = state_q;
    cke_d       = cmd_pins_in.cke;
    cke_hold_d  = count_down(cke_hold_q);
    open_d      = open_q;
    wtr_d       = count_down(wtr_q);
    xp_d        = count_down(xp_q);
    wr_clocks_d = wr_clocks_q;
    strobe_d    = strobe_q;
    suspect_d   = suspect_q;
    ev          = '0;
    code        = cmd_code(cmd_pins_in);
    cmd_ok      = cke_q & cmd_pins_in.cke;
    for (int i = 0; i < `BANK_COUNT; i++) begin
      act_cnt_d[i] = count_down(act_cnt_q[i]); // [R10]
    end
    // A level change restarts the hold count; a change inside it is a glitch.
    if (cmd_pins_in.cke != cke_q) begin
      cke_hold_d = CKE_LOAD; // [R06]
      if (cke_hold_q != '0) begin
        ev.cke_glitch = 1'b1; // [R06]
      end
    end
    if (cmd_ok) begin
      case (code)
        `CMD_MODE_LOAD: begin
          if (cmd_pins_in.ba == `MODE_BANK_MAIN) begin
            wr_clocks_d = {1'b0, cmd_pins_in.addr[`WR_FIELD_MSB:`WR_FIELD_LSB]} + 4'h1; // [R02]
          end
          if (cmd_pins_in.ba == `MODE_BANK_EXT) begin
            strobe_d = cmd_pins_in.addr[`STROBE_MODE_BIT]; // [R04]
          end
        end
        `CMD_PRECHARGE: begin
          for (int i = 0; i < `BANK_COUNT; i++) begin
            if (cmd_pins_in.addr[`AUTO_PRE_BIT] || (cmd_pins_in.ba == `BANK_W'(i))) begin
              open_d[i]    = 1'b0;
              act_cnt_d[i] = RP_LOAD; // [R08]
            end
          end
        end
        `CMD_ACTIVATE: begin
          // An activate exactly at the rounded count sees a zero counter.
          if (act_cnt_q[cmd_pins_in.ba] != '0) begin
            ev.act_early = 1'b1; // [R01] [R08] [R10]
          end
          if (xp_q != '0) begin
            ev.exit_early = 1'b1; // [R09]
          end
          open_d[cmd_pins_in.ba] = 1'b1;
        end
        `CMD_WRITE: begin
          wtr_d     = WTR_LOAD; // [R05]
          suspect_d = 1'b0; // [R07]
          if (cmd_pins_in.addr[`AUTO_PRE_BIT]) begin
            open_d[cmd_pins_in.ba]    = 1'b0;
            act_cnt_d[cmd_pins_in.ba] = `CNT_W'(wr_clocks_q) + RP_LOAD; // [R01] [R02]
          end
        end
        `CMD_READ: begin
          if (wtr_q != '0) begin
            ev.read_early = 1'b1; // [R05]
          end
          if (suspect_q) begin
            ev.read_suspect = 1'b1; // [R07]
          end
          if (cmd_pins_in.addr[`AUTO_PRE_BIT]) begin
            open_d[cmd_pins_in.ba]    = 1'b0;
            act_cnt_d[cmd_pins_in.ba] = RP_LOAD;
          end
        end
        default: begin
        end
      endcase
    end
    // Power state follows registered clock enable edges.
    case (state_q)
      ST_ACTIVE: begin
        if (cke_q && !cmd_pins_in.cke) begin
          if (code == `CMD_REFRESH) begin
            state_d = ST_SELF_REF;
          end else if (open_q != '0) begin
            state_d = ST_PD_ACT;
          end else begin
            state_d = ST_PD_PRE;
          end
        end
      end
      ST_PD_PRE, ST_PD_ACT: begin
        if (!cke_q && cmd_pins_in.cke) begin
          state_d = ST_ACTIVE;
          xp_d    = XP_LOAD; // [R09]
        end
      end
      ST_SELF_REF: begin
        if (!cke_q && cmd_pins_in.cke) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
    // A fault in the same edge as a write leaves the data suspect.
    if (data_fault_in) begin
      suspect_d = 1'b1; // [R07]
    end
    fault_tog_d = fault_tog_q ^ ev;
  end

  // Link domain registers.
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      state_q     <= ST_ACTIVE;
      cke_q       <= 1'b0;
      cke_hold_q  <= '0;
      open_q      <= '0;
      wtr_q       <= '0;
      xp_q        <= '0;
      wr_clocks_q <= `WR_CLOCKS_RESET;
      strobe_q    <= `STROBE_RESET;
      suspect_q   <= 1'b0;
      fault_tog_q <= '0;
      for (int i = 0; i < `BANK_COUNT; i++) begin
        act_cnt_q[i] <= '0;
      end
    end else begin
      state_q     <= state_d;
      cke_q       <= cke_d;
      cke_hold_q  <= cke_hold_d;
      open_q      <= open_d;
      wtr_q       <= wtr_d;
      xp_q        <= xp_d;
      wr_clocks_q <= wr_clocks_d;
      strobe_q    <= strobe_d;
      suspect_q   <= suspect_d;
      fault_tog_q <= fault_tog_d;
      for (int i = 0; i < `BANK_COUNT; i++) begin
        act_cnt_q[i] <= act_cnt_d[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crossing to the system clock
  // ----------------------------------------------------------------------
  dev_status_t link_status;
  dev_status_t sync_status;
  fault_t      sync_tog;

  // Frequency change is permitted only in self-refresh or precharge power-down.
  assign link_status.strobe_single_ended = strobe_q; // [R04]
  assign link_status.freq_change_ok      = (state_q == ST_SELF_REF) || (state_q == ST_PD_PRE); // [R03]
  assign link_status.self_refresh        = (state_q == ST_SELF_REF);
  assign link_status.power_down          = (state_q == ST_PD_PRE) || (state_q == ST_PD_ACT);

  level_sync #(.WIDTH($bits(dev_status_t) + $bits(fault_t))) u_status_sync (
    .clk_in (ref_clk_in),
    .d_in   ({link_status, fault_tog_q}),
    .q_out  ({sync_status, sync_tog})
  );

  // ----------------------------------------------------------------------
  // System domain outputs
  // ----------------------------------------------------------------------
  fault_t      tog_prev_q, tog_prev_d;
  dev_status_t status_d;
  fault_t      fault_d;

  // Toggle edges become one-cycle pulses; levels are registered.
  always_comb begin
    tog_prev_d = sync_tog;
    status_d   = sync_status;
    fault_d    = sync_tog ^ tog_prev_q;
  end

  // System domain registers.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      tog_prev_q <= '0;
      status_out <= '0;
      fault_out  <= '0;
    end else begin
      tog_prev_q <= tog_prev_d;
      status_out <= status_d;
      fault_out  <= fault_d;
    end
  end

endmodule : ddr2_command_timing_rules
`default_nettype wire

// >>> testbench/ddr2_command_timing_rules_monitor.sv
// Concurrent checks on the outputs of the command timing block.
`timescale 1ns/1ps
`default_nettype none

module ddr2_command_timing_rules_monitor (
  input wire logic                         ref_clk_in,     // System clock.
  input wire logic                         rstn_in,        // Reset, active low.
  input wire logic                         link_clk_in,    // Link clock.
  input wire ddr2_timing_pkg::cmd_pins_t   cmd_pins_in,    // Command pins.
  input wire logic                         data_fault_in,  // Write data fault.
  input wire ddr2_timing_pkg::dev_status_t status_out,     // Status levels.
  input wire ddr2_timing_pkg::fault_t      fault_out       // Fault pulses.
);
  import ddr2_timing_pkg::*;

  // ------------------------------------------------------------------
  // Properties on the system clock
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  // A stretch of eight consecutive system clocks with power-down reported.
  sequence s_pd_steady;
    status_out.power_down [*8];
  endsequence
  sequence s_sr_held;
    status_out.self_refresh ##1 status_out.self_refresh;
  endsequence

  property p_freq_src;
    status_out.freq_change_ok |->
      (status_out.self_refresh || status_out.power_down || $past(status_out.power_down));
  endproperty
  property p_sr_freq;
    s_sr_held |-> status_out.freq_change_ok && !status_out.power_down;
  endproperty
  property p_strobe_hold;
    s_sr_held |-> $stable(status_out.strobe_single_ended);
  endproperty
  property p_act_pulse;
    $rose(fault_out.act_early) |=> !fault_out.act_early;
  endproperty
  property p_read_pulse;
    $rose(fault_out.read_early) |=> !fault_out.read_early;
  endproperty
  property p_pd_exit;
    s_pd_steady |-> !fault_out.exit_early;
  endproperty

  a_freq_src: assert property (p_freq_src)
    else $error("frequency change allowed outside low power states");
  a_sr_freq: assert property (p_sr_freq)
    else $error("self refresh without frequency change permission");
  a_strobe_hold: assert property (p_strobe_hold)
    else $error("strobe style changed during self refresh");
  a_act_pulse: assert property (p_act_pulse)
    else $error("early activate flag longer than one cycle");
  a_read_pulse: assert property (p_read_pulse)
    else $error("early read flag longer than one cycle");
  a_pd_exit: assert property (p_pd_exit)
    else $error("exit gap flag while still powered down");
endmodule : ddr2_command_timing_rules_monitor

bind ddr2_command_timing_rules ddr2_command_timing_rules_monitor u_mon (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
  .cmd_pins_in(cmd_pins_in), .data_fault_in(data_fault_in),
  .status_out(status_out), .fault_out(fault_out));
`default_nettype wire

// >>> testbench/ddr2_ctl_model.sv
// Memory controller model that drives commands on the link clock.
`timescale 1ns/1ps
`default_nettype none

module ddr2_ctl_model (
  input  wire logic                 link_clk_in,   // Link clock.
  output ddr2_timing_pkg::cmd_pins_t cmd_pins_out, // Command pins.
  output logic                      fault_out      // Write data timing fault.
);
  import ddr2_timing_pkg::*;
  logic cke_lvl;  // Clock enable level driven on every edge.

  // Idle pins: deselected, clock enable low.
  initial begin
    cke_lvl = 1'b0;
    cmd_pins_out = {1'b0, 4'hf, 3'h0, 14'h0};
    fault_out = 1'b0;
  end

  // One command per edge, so spacing equals the number of calls.
  task automatic issue(input logic [3:0] code, input logic [2:0] ba,
                       input logic [13:0] a, input logic flt);
    @(posedge link_clk_in);
    cmd_pins_out <= {cke_lvl, code, ba, a};
    fault_out <= flt;
  endtask : issue

  // No operation; the idle pins show the inverse of their last value.
  task automatic nop(input int n);
    repeat (n) issue(4'h7, ~cmd_pins_out.ba, ~cmd_pins_out.addr, 1'b0);
  endtask : nop

  // Clock enable change together with the command of that edge.
  task automatic cke(input logic v, input logic [3:0] code);
    cke_lvl = v;
    issue(code, 3'($urandom), 14'($urandom), 1'b0);
  endtask : cke
endmodule : ddr2_ctl_model
`default_nettype wire

// >>> testbench/ddr2_command_timing_rules_tb_top.sv
// Self-checking bench for the command timing block.
`timescale 1ns/1ps
`default_nettype none

module ddr2_command_timing_rules_tb_top;
  import ddr2_timing_pkg::*;
  logic        ref_clk = 1'b0;   // System clock.
  logic        link_clk = 1'b0;  // Link clock.
  logic        rstn = 1'b0;      // Reset, active low.
  cmd_pins_t   cmd_pins;         // Command pins.
  logic        data_fault;       // Write data fault.
  dev_status_t status;           // Status levels.
  fault_t      fault;            // Fault pulses.
  fault_t      exp_q[$];         // Expected fault pulses, oldest first.
  int          err_total = 0;
  int          cmp_count = 0;
  logic [2:0]  wf;               // Write recovery field.
  logic [2:0]  bk;               // Bank under test.

  // Clocks with unrelated phases.
  always #10 ref_clk = ~ref_clk;
  always #32 link_clk = ~link_clk;

  ddr2_ctl_model u_ctl (.link_clk_in(link_clk), .cmd_pins_out(cmd_pins), .fault_out(data_fault));
  ddr2_command_timing_rules DUT (.ref_clk_in(ref_clk), .rstn_in(rstn), .link_clk_in(link_clk),
    .cmd_pins_in(cmd_pins), .data_fault_in(data_fault), .status_out(status), .fault_out(fault));

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic cmp_fault(input fault_t e, input fault_t g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t fault exp %h got %h", $time, e, g);
    end
  endtask : cmp_fault

  task automatic cmp_stat(input dev_status_t e);
    cmp_count++;
    if (status !== e) begin
      err_total++;
      $display("[FAIL] %0t status exp %h got %h", $time, e, status);
    end
  endtask : cmp_stat

  // Random address with only the auto-precharge bit chosen, so unused bits vary.
  function automatic logic [13:0] rnd_addr(input logic ap);
    logic [13:0] a;
    a = 14'($urandom);
    a[10] = ap;
    return a;
  endfunction : rnd_addr

  // Each fault pulse is matched against the oldest note.
  always @(posedge ref_clk) begin
    if (rstn && fault !== 5'h0) begin
      if (exp_q.size() == 0) cmp_fault(5'h0, fault);
      else cmp_fault(exp_q.pop_front(), fault);
    end
  end

  // Watchdog against a hung run.
  initial begin
    #400000;
    err_total++;
    conclude();
  end

  // Main sequence.
  initial begin
    void'($urandom(28915));
    wf = 3'($urandom_range(1, 5));
    bk = 3'($urandom_range(0, 7));
    repeat (14) @(posedge ref_clk);
    rstn <= 1'b1;
    u_ctl.nop(5);
    u_ctl.cke(1'b1, 4'h7);
    u_ctl.nop(4);
    u_ctl.issue(4'h0, 3'h0, (rnd_addr(1'b0) & 14'h31ff) | {2'h0, wf, 9'h0}, 1'b0);
    u_ctl.issue(4'h0, 3'h1, rnd_addr(1'b1), 1'b0);
    u_ctl.nop(4);
    cmp_stat(4'b1000);
    u_ctl.issue(4'h0, 3'h1, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    cmp_stat(4'b0000);
    $display("test mode loads ended");
    u_ctl.issue(4'h2, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.issue(4'h3, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    exp_q.push_back(5'b10000);
    u_ctl.issue(4'h4, bk, rnd_addr(1'b1), 1'b0);
    u_ctl.nop(int'(wf));
    u_ctl.issue(4'h3, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    u_ctl.issue(4'h4, bk, rnd_addr(1'b1), 1'b0);
    u_ctl.nop(int'(wf) + 1);
    u_ctl.issue(4'h3, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    $display("test auto precharge ended");
    exp_q.push_back(5'b01000);
    u_ctl.issue(4'h4, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.issue(4'h5, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    u_ctl.issue(4'h4, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(1);
    u_ctl.issue(4'h5, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    exp_q.push_back(5'b00001);
    u_ctl.issue(4'h7, bk, rnd_addr(1'b0), 1'b1);
    u_ctl.issue(4'h5, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    u_ctl.issue(4'h4, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(1);
    u_ctl.issue(4'h5, bk, rnd_addr(1'b0), 1'b0);
    u_ctl.nop(4);
    $display("test write read ended");
    for (int i = 0; i < 2; i++) begin
      u_ctl.issue(4'h2, 3'($urandom), rnd_addr(1'b1), 1'b0);
      u_ctl.nop(2);
      u_ctl.cke(1'b0, 4'h7);
      u_ctl.nop(3);
      cmp_stat(4'b0101);
      if (i == 0) exp_q.push_back(5'b00010);
      u_ctl.cke(1'b1, 4'h7);
      u_ctl.nop(i);
      u_ctl.issue(4'h3, bk, rnd_addr(1'b0), 1'b0);
      u_ctl.nop(4);
    end
    // Bank bk is open here, so clock enable low enters active power-down.
    u_ctl.cke(1'b0, 4'h7);
    u_ctl.nop(3);
    cmp_stat(4'b0001);
    u_ctl.cke(1'b1, 4'h7);
    u_ctl.nop(4);
    u_ctl.issue(4'h2, 3'($urandom), rnd_addr(1'b1), 1'b0);
    u_ctl.nop(2);
    u_ctl.cke(1'b0, 4'h1);
    u_ctl.nop(3);
    cmp_stat(4'b0110);
    u_ctl.cke(1'b1, 4'h7);
    u_ctl.nop(4);
    $display("test low power ended");
    exp_q.push_back(5'b00100);
    u_ctl.cke(1'b0, 4'h7);
    u_ctl.cke(1'b1, 4'h7);
    u_ctl.nop(6);
    repeat (20) @(posedge ref_clk);
    cmp_count++;
    if (exp_q.size() != 0) begin
      err_total++;
      $display("[FAIL] %0t pulses missing exp %h got %h", $time, 0, exp_q.size());
    end
    $display("test clock enable ended");
    conclude();
  end
endmodule : ddr2_command_timing_rules_tb_top
`default_nettype wire
